/* lar_pkg.sv */
// constants shared by the linear array sensor end and its controller end
package lar_pkg;
  localparam int NPIX = 102;
  localparam logic [6:0] PIX_LAST = 7'h65;
  localparam logic [6:0] ZONE_B1 = 7'h22;
  localparam logic [6:0] ZONE_B2 = 7'h44;
  localparam logic [7:0] CMD_RESET = 8'h1b;
  localparam logic [7:0] CMD_START = 8'h08;
  localparam logic [7:0] CMD_SAMPLE = 8'h10;
  localparam logic [7:0] CMD_DUMP = 8'h02;
  localparam logic [7:0] CMD_CANCEL = 8'h19;
  localparam logic [2:0] CMD_REGWR_TOP = 3'h2;
  localparam logic [4:0] REG_LAST = 5'h05;
  localparam int START_DELAY_CYC = 22;
  localparam int DUMP_DELAY_CYC = 44;
  localparam logic [5:0] START_WAIT_LAST = 6'(START_DELAY_CYC - 2);
  localparam logic [5:0] DUMP_WAIT_LAST = 6'(DUMP_DELAY_CYC - 2);
  localparam logic [2:0] DATA_LAST = 3'h7;
  localparam logic [3:0] FRAME_STOP = 4'h9;
  localparam logic [3:0] FRAME_BITS = 4'ha;
  localparam logic [5:0] GAIN_UNITY = 6'h20;
  localparam int GAIN_SHIFT = 5;
  localparam logic [7:0] CODE_MAX = 8'hff;
  localparam logic [1:0] SCLK_HALF_LAST = 2'h1;
  localparam logic [2:0] RX_FIRST_WAIT = 3'h5;
  localparam logic [2:0] RX_BIT_WAIT = 3'h3;
  localparam logic [3:0] ADDR_TX = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_RX = 4'h8;
  localparam int ST_BUSY = 0;
  localparam int ST_RXVALID = 1;
  localparam int ST_OVERRUN = 2;
endpackage

/* lar_if.sv */
// serial link between the array sensor and its controller
`timescale 1ns/10ps
interface lar_if;
  logic sclk;
  logic serial_cmd_in;
  logic serial_pixel_out;
  modport sensor(input sclk, input serial_cmd_in, output serial_pixel_out);
  modport ctrl(output sclk, output serial_cmd_in, input serial_pixel_out);
endinterface

/* lar_sensor.sv */
// sensor end: command receiver, integration control, pixel store and serial dump
`timescale 1ns/10ps
module lar_sensor
  import lar_pkg::*;
(
  input wire logic hresetn,
  lar_if.sensor link,
  output logic [6:0] photo_sel,
  input wire logic [7:0] photo_in
);
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_DATA = 2'b10} lar_rx_e;
  typedef enum logic [2:0] {
    IN_RESET = 3'b001, IN_WAIT = 3'b010, IN_RUN = 3'b100
  } lar_int_e;
  typedef enum logic [2:0] {
    RO_IDLE = 3'b001, RO_DELAY = 3'b010, RO_SEND = 3'b100
  } lar_ro_e;

  lar_rx_e rx_st;
  lar_int_e int_st;
  lar_ro_e ro_st;
  logic [7:0] rx_shift;
  logic [2:0] rx_cnt;
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic wr_pend;
  logic [4:0] wr_addr;
  logic [7:0] offs [3];
  logic [4:0] gain [3];
  logic [5:0] wcnt;
  logic [5:0] dcnt;
  logic [6:0] pix;
  logic [3:0] bit_idx;
  logic tx_bit;
  logic [7:0] acc [NPIX];
  logic [7:0] held [NPIX];
  logic is_cmd;
  logic is_reset;
  logic is_start;
  logic is_sample;
  logic is_dump;
  logic is_cancel;
  logic [1:0] zone;
  logic [7:0] samp;
  logic [9:0] corr;
  logic [15:0] scaled;
  logic [7:0] conv;

  // stop bits are optional, so the receiver is ready for a start bit right after bit 7
  always_ff @(posedge link.sclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st <= RX_IDLE;
      rx_cnt <= 3'h0;
      rx_shift <= 8'h00;
      cmd_valid <= 1'b0;
      cmd_byte <= 8'h00;
    end else begin
      cmd_valid <= 1'b0;
      case (rx_st)
        RX_IDLE: begin
          if (!link.serial_cmd_in) begin
            rx_st <= RX_DATA;
            rx_cnt <= 3'h0;
          end
        end
        RX_DATA: begin
          rx_shift <= {link.serial_cmd_in, rx_shift[7:1]};
          rx_cnt <= rx_cnt + 3'h1;
          if (rx_cnt == DATA_LAST) begin
            rx_st <= RX_IDLE;
            cmd_valid <= 1'b1;
            cmd_byte <= {link.serial_cmd_in, rx_shift[7:1]};
          end
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  assign is_cmd = cmd_valid && !wr_pend;
  assign is_reset = is_cmd && (cmd_byte == CMD_RESET);
  assign is_start = is_cmd && (cmd_byte == CMD_START);
  assign is_sample = is_cmd && (cmd_byte == CMD_SAMPLE);
  assign is_dump = is_cmd && (cmd_byte == CMD_DUMP);
  assign is_cancel = is_cmd && (cmd_byte == CMD_CANCEL);

  // register write takes two bytes; addresses above REG_LAST are dropped
  always_ff @(posedge link.sclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 5'h00;
      for (int z = 0; z < 3; z++) begin
        offs[z] <= 8'h00;
        gain[z] <= 5'h00;
      end
    end else if (cmd_valid) begin
      if (wr_pend) begin
        wr_pend <= 1'b0;
        if (wr_addr <= REG_LAST) begin
          if (wr_addr[0]) begin
            gain[wr_addr[2:1]] <= cmd_byte[4:0];
          end else begin
            offs[wr_addr[2:1]] <= cmd_byte;
          end
        end
      end else if (cmd_byte[7:5] == CMD_REGWR_TOP) begin
        wr_pend <= 1'b1;
        wr_addr <= cmd_byte[4:0];
      end
    end
  end

  always_ff @(posedge link.sclk or negedge hresetn) begin
    if (!hresetn) begin
      int_st <= IN_RESET;
      wcnt <= 6'h00;
    end else if (is_reset || is_sample) begin
      int_st <= IN_RESET;
    end else if (is_start) begin
      int_st <= IN_WAIT;
      wcnt <= 6'h00;
    end else begin
      case (int_st)
        IN_RESET: int_st <= IN_RESET;
        IN_WAIT: begin
          wcnt <= wcnt + 6'h01;
          if (wcnt == START_WAIT_LAST) begin
            int_st <= IN_RUN;
          end
        end
        IN_RUN: int_st <= IN_RUN;
        default: int_st <= IN_RESET;
      endcase
    end
  end

  // the photo input is scanned one pixel per clock, so each pixel sees one of every 102 edges
  always_ff @(posedge link.sclk or negedge hresetn) begin
    if (!hresetn) begin
      photo_sel <= 7'h00;
    end else if (photo_sel == PIX_LAST) begin
      photo_sel <= 7'h00;
    end else begin
      photo_sel <= photo_sel + 7'h01;
    end
  end

  // integrators stay cleared outside the run state, saturating rather than wrapping
  always_ff @(posedge link.sclk) begin
    for (int p = 0; p < NPIX; p++) begin
      if (int_st != IN_RUN || is_reset || is_sample) begin
        acc[p] <= 8'h00;
      end else if (p == int'(photo_sel)) begin
        acc[p] <= (acc[p] > CODE_MAX - photo_in) ? CODE_MAX : acc[p] + photo_in;
      end
    end
  end

  always_ff @(posedge link.sclk) begin
    for (int p = 0; p < NPIX; p++) begin
      if (is_reset) begin
        held[p] <= 8'h00;
      end else if (is_sample) begin
        held[p] <= acc[p];
      end
    end
  end

  // conversion of the pixel under readout
  always_comb begin
    if (pix < ZONE_B1) begin
      zone = 2'd0;
    end else if (pix < ZONE_B2) begin
      zone = 2'd1;
    end else begin
      zone = 2'd2;
    end
    samp = held[pix];
    if (offs[zone][7]) begin
      corr = (samp >= {1'b0, offs[zone][6:0]}) ? {2'b00, samp - {1'b0, offs[zone][6:0]}} : 10'h000;
    end else begin
      corr = {2'b00, samp} + {3'b000, offs[zone][6:0]};
    end
    scaled = 16'(corr) * 16'({1'b0, gain[zone]} + GAIN_UNITY);
    conv = (scaled[15:GAIN_SHIFT] > 11'(CODE_MAX)) ? CODE_MAX : scaled[GAIN_SHIFT +: 8];
  end

  always_ff @(posedge link.sclk or negedge hresetn) begin
    if (!hresetn) begin
      ro_st <= RO_IDLE;
      dcnt <= 6'h00;
      pix <= 7'h00;
      bit_idx <= 4'h0;
      tx_bit <= 1'b1;
    end else if (is_reset || is_cancel) begin
      ro_st <= RO_IDLE;
      tx_bit <= 1'b1;
    end else if (is_dump) begin
      ro_st <= RO_DELAY;
      dcnt <= 6'h00;
      tx_bit <= 1'b1;
    end else begin
      case (ro_st)
        RO_IDLE: tx_bit <= 1'b1;
        RO_DELAY: begin
          dcnt <= dcnt + 6'h01;
          if (dcnt == DUMP_WAIT_LAST) begin
            ro_st <= RO_SEND;
            pix <= 7'h00;
            bit_idx <= 4'h0;
            tx_bit <= 1'b0;
          end
        end
        RO_SEND: begin
          if (bit_idx == FRAME_STOP) begin
            if (pix == PIX_LAST) begin
              ro_st <= RO_IDLE;
              tx_bit <= 1'b1;
            end else begin
              pix <= pix + 7'h01;
              bit_idx <= 4'h0;
              tx_bit <= 1'b0;
            end
          end else begin
            bit_idx <= bit_idx + 4'h1;
            tx_bit <= (bit_idx == FRAME_STOP - 4'h1) ? 1'b1 : conv[bit_idx[2:0]];
          end
        end
        default: ro_st <= RO_IDLE;
      endcase
    end
  end

  // the controller samples on the rising edge, so the line moves half a clock earlier
  always_ff @(negedge link.sclk or negedge hresetn) begin
    if (!hresetn) begin
      link.serial_pixel_out <= 1'b1;
    end else begin
      link.serial_pixel_out <= tx_bit;
    end
  end
endmodule

/* lar_ctrl.sv */
// controller end: AHB-Lite registers, serial clock divider, command sender, pixel receiver
`timescale 1ns/10ps
module lar_ctrl
  import lar_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  lar_if.ctrl link
);
  typedef enum logic [1:0] {CR_IDLE = 2'b01, CR_BITS = 2'b10} lar_crx_e;

  logic [1:0] hcnt;
  logic sclk_fall;
  logic [9:0] tx_sh;
  logic [3:0] tx_left;
  logic dp_wr;
  logic [3:0] dp_addr;
  logic take;
  logic s1;
  logic s2;
  logic s3;
  logic filt;
  lar_crx_e crx_st;
  logic [2:0] rcnt;
  logic [3:0] rbits;
  logic [7:0] rx_sh;
  logic [7:0] rx_byte;
  logic rx_done;
  logic rx_valid;
  logic overrun;

  // serial clock is hclk divided by four; commands only run while it toggles
  assign sclk_fall = (hcnt == SCLK_HALF_LAST) && link.sclk;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hcnt <= 2'h0;
      link.sclk <= 1'b0;
    end else if (hcnt == SCLK_HALF_LAST) begin
      hcnt <= 2'h0;
      link.sclk <= ~link.sclk;
    end else begin
      hcnt <= hcnt + 2'h1;
    end
  end

  assign take = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_addr <= 4'h0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      dp_wr <= take && hwrite;
      dp_addr <= haddr[3:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (take && !hwrite) begin
        case (haddr[3:0])
          ADDR_STATUS: hrdata <= {29'h0, overrun, rx_valid, tx_left != 4'h0};
          ADDR_RX: hrdata <= {24'h0, rx_byte};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // a byte written while the sender is busy is dropped; software polls the busy bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_sh <= 10'h3ff;
      tx_left <= 4'h0;
      link.serial_cmd_in <= 1'b1;
    end else if (dp_wr && dp_addr == ADDR_TX && tx_left == 4'h0) begin
      tx_sh <= {1'b1, hwdata[7:0], 1'b0};
      tx_left <= FRAME_BITS;
    end else if (sclk_fall) begin
      if (tx_left != 4'h0) begin
        link.serial_cmd_in <= tx_sh[0];
        tx_sh <= {1'b1, tx_sh[9:1]};
        tx_left <= tx_left - 4'h1;
      end else begin
        link.serial_cmd_in <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      filt <= 1'b1;
    end else begin
      s1 <= link.serial_pixel_out;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        filt <= s3;
      end
    end
  end

  // bits are taken mid-period, well clear of the falling-edge change on the line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crx_st <= CR_IDLE;
      rcnt <= 3'h0;
      rbits <= 4'h0;
      rx_sh <= 8'h00;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      case (crx_st)
        CR_IDLE: begin
          if (filt && s2 == s3 && !s3) begin
            crx_st <= CR_BITS;
            rcnt <= RX_FIRST_WAIT;
            rbits <= 4'h0;
          end
        end
        CR_BITS: begin
          if (rcnt == 3'h0) begin
            rx_sh <= {filt, rx_sh[7:1]};
            rcnt <= RX_BIT_WAIT;
            rbits <= rbits + 4'h1;
            if (rbits == {1'b0, DATA_LAST}) begin
              crx_st <= CR_IDLE;
              rx_done <= 1'b1;
            end
          end else begin
            rcnt <= rcnt - 3'h1;
          end
        end
        default: crx_st <= CR_IDLE;
      endcase
    end
  end

  // a new byte wins over a read that clears the flag in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
      overrun <= 1'b0;
    end else begin
      if (rx_done) begin
        rx_byte <= rx_sh;
        rx_valid <= 1'b1;
        overrun <= overrun | rx_valid;
      end else if (take && !hwrite && haddr[3:0] == ADDR_RX) begin
        rx_valid <= 1'b0;
        overrun <= 1'b0;
      end
    end
  end
endmodule

/* lar_link_properties.sv */
// assertions on the serial link between the sensor end and the controller end
`timescale 1ns/10ps
module lar_link_properties
  import lar_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sclk,
  input wire logic serial_cmd_in,
  input wire logic serial_pixel_out
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [3:0] ibit;
  logic [3:0] obit;
  logic [7:0] sh;
  logic [7:0] fcnt;
  logic [6:0] rcnt;
  logic wdat;
  logic dwait;
  logic quiet;
  wire logic [7:0] rx_byte = {serial_cmd_in, sh[7:1]};
  // command frames, taken where sclk rises
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ibit <= 4'h0;
      sh <= 8'h00;
    end else if ($rose(sclk)) begin
      if (ibit == 4'h0) begin
        ibit <= {3'h0, !serial_cmd_in};
      end else begin
        ibit <= (ibit == FRAME_STOP) ? 4'h0 : ibit + 4'h1;
        sh <= rx_byte;
      end
    end
  end
  // data byte after a register write opcode must not be decoded as a command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdat <= 1'b0;
      dwait <= 1'b0;
      quiet <= 1'b0;
    end else if ($rose(sclk) && ibit == 4'h8) begin
      wdat <= !wdat && rx_byte[7:5] == CMD_REGWR_TOP;
      if (!wdat && rx_byte == CMD_DUMP) begin
        dwait <= 1'b1;
        quiet <= 1'b0;
      end
      if (!wdat && (rx_byte == CMD_CANCEL || rx_byte == CMD_RESET)) begin
        dwait <= 1'b0;
        quiet <= 1'b1;
      end
    end else if ($fell(sclk) && dwait && rcnt == 7'(DUMP_DELAY_CYC)) begin
      dwait <= 1'b0;
    end
  end
  // edges counted from the edge that took the last data bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rcnt <= 7'h00;
      fcnt <= 8'h00;
    end else if ($rose(sclk) && ibit == 4'h8) begin
      rcnt <= 7'h00;
      fcnt <= 8'h00;
    end else begin
      if ($rose(sclk) && rcnt != 7'h7f) rcnt <= rcnt + 7'h01;
      if ($fell(sclk) && fcnt != 8'hff) fcnt <= fcnt + 8'h01;
    end
  end
  // pixel frames, seen where sclk falls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      obit <= 4'h0;
    end else if ($fell(sclk)) begin
      if (obit == 4'h0) obit <= {3'h0, !serial_pixel_out};
      else obit <= (obit == FRAME_STOP) ? 4'h0 : obit + 4'h1;
    end
  end
  a_sclk_period: assert property ($rose(sclk) |=> sclk ##1 !sclk)
    else $error("serial clock period wrong");
  a_serial_cmd_in_launch: assert property ($changed(serial_cmd_in) |-> $fell(sclk))
    else $error("command line moved off the falling edge");
  a_serial_pixel_out_launch: assert property ($changed(serial_pixel_out) |-> $fell(sclk))
    else $error("pixel line moved off the falling edge");
  a_cmd_stop: assert property ($rose(sclk) && ibit == FRAME_STOP |-> serial_cmd_in)
    else $error("command frame without stop bit");
  a_pixel_stop: assert property ($fell(sclk) && obit == FRAME_STOP |-> serial_pixel_out)
    else $error("pixel frame without stop bit");
  a_dump_quiet: assert property (dwait && rcnt < 7'(DUMP_DELAY_CYC) |-> serial_pixel_out)
    else $error("pixel output before its delay");
  a_dump_first: assert property ($fell(sclk) && dwait && rcnt == 7'(DUMP_DELAY_CYC) |-> !serial_pixel_out)
    else $error("first pixel start bit missing");
  a_cancel_idle: assert property (quiet && fcnt >= 8'h02 |-> serial_pixel_out)
    else $error("pixel output after cancel or reset");
endmodule

/* linear_array_readout_control_test.sv */
// bench: registers of the controller drive the sensor end over the link
`timescale 1ns/10ps
module linear_array_readout_control_test;
  import lar_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] photo_in = 8'h80;
  wire logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [6:0] photo_sel;
  int errors = 0;
  int check_count = 0;
  logic [7:0] ofs [3];
  logic [4:0] gn [3];
  lar_if u_lar_if();
  assign hready = hreadyout;
  lar_ctrl u_lar_ctrl(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(u_lar_if.ctrl));
  lar_sensor u_lar_sensor(.hresetn(hresetn), .link(u_lar_if.sensor), .photo_sel(photo_sel),
    .photo_in(photo_in));
  lar_link_properties u_lar_link_properties(.hclk(hclk), .hresetn(hresetn),
    .sclk(u_lar_if.sclk), .serial_cmd_in(u_lar_if.serial_cmd_in), .serial_pixel_out(u_lar_if.serial_pixel_out));
  always #12.5 hclk = ~hclk;
  // at least half scale each pass, so a long integration saturates every pixel
  // moved on the falling serial edge so it never races the sensor's rising edge
  always @(negedge u_lar_if.sclk) photo_in <= {1'b1, photo_sel};
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic give_up(input int n, input int lim);
    if (n >= lim) begin
      errors++;
      close_out();
    end
  endtask
  task automatic edge_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    give_up((hready !== 1'b1) ? 20 : 0, 20);
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {28'h0, a};
    hwrite <= wr;
    edge_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    edge_ready();
    rd = hrdata;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0, d);
  endtask
  task automatic send(input logic [7:0] b);
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      rd(ADDR_STATUS, s);
      n++;
    end while (s[ST_BUSY] !== 1'b0 && n < 200);
    give_up((s[ST_BUSY] !== 1'b0) ? 200 : 0, 200);
    bus(1'b1, ADDR_TX, {24'h0, b}, s);
  endtask
  task automatic pull(output logic [7:0] b);
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      rd(ADDR_STATUS, s);
      n++;
    end while (s[ST_RXVALID] !== 1'b1 && n < 400);
    give_up((s[ST_RXVALID] !== 1'b1) ? 400 : 0, 400);
    rd(ADDR_RX, s);
    b = s[7:0];
  endtask
  function automatic logic [7:0] expect_px(input int held, input logic [7:0] off,
    input logic [4:0] g);
    int v;
    v = off[7] ? held - int'(off[6:0]) : held + int'(off[6:0]);
    v = (v < 0) ? 0 : v;
    v = v * (int'(GAIN_UNITY) + int'(g)) / int'(GAIN_UNITY);
    return (v > int'(CODE_MAX)) ? CODE_MAX : 8'(v);
  endfunction
  // gain goes before offset, since the offset scales with the gain
  task automatic setup(input logic [23:0] o, input logic [14:0] g);
    for (int z = 0; z < 3; z++) begin
      ofs[z] = o[8*z +: 8];
      gn[z] = g[5*z +: 5];
      send(8'h41 + 8'(2*z));
      send({3'h0, gn[z]});
      send(8'h40 + 8'(2*z));
      send(ofs[z]);
    end
  endtask
  task automatic dump(input int held);
    logic [7:0] b;
    logic [31:0] s;
    int z;
    send(CMD_DUMP);
    for (int p = 0; p < NPIX; p++) begin
      z = (p < int'(ZONE_B1)) ? 0 : (p < int'(ZONE_B2)) ? 1 : 2;
      pull(b);
      check("pixel", {24'h0, b}, {24'h0, expect_px(held, ofs[z], gn[z])});
    end
    repeat (300) @(posedge hclk);
    rd(ADDR_STATUS, s);
    check("status after dump", s, 32'h0);
  endtask
  // normal sequence: reset, start, wait, sample, dump
  initial begin
    logic [31:0] s;
    logic [7:0] b;
    // a real falling edge, so the sensor's asynchronous reset fires before its clock runs
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ADDR_STATUS, s);
    check("status after reset", s, 32'h0);
    @(negedge u_lar_if.sclk);
    b = {1'b0, photo_sel};
    @(negedge u_lar_if.sclk);
    check("pixel scan", {25'h0, photo_sel},
      {25'h0, (b[6:0] == PIX_LAST) ? 7'h00 : b[6:0] + 7'h01});
    rd(4'hc, s);
    check("unmapped read", s, 32'h0);
    check("response", {31'h0, hresp}, 32'h0);
    send(CMD_RESET);
    setup({8'h30, 8'h20, 8'h10}, {5'h1f, 5'h10, 5'h00});
    send(CMD_SAMPLE);
    dump(0);
    setup({8'hff, 8'hf0, 8'h90}, {5'h1f, 5'h10, 5'h00});
    send(CMD_START);
    repeat (1000) @(posedge hclk);
    send(CMD_SAMPLE);
    dump(int'(CODE_MAX));
    send(CMD_DUMP);
    pull(b);
    check("held pixel", {24'h0, b}, {24'h0, expect_px(int'(CODE_MAX), ofs[0], gn[0])});
    send(CMD_CANCEL);
    repeat (200) @(posedge hclk);
    rd(ADDR_RX, s);
    repeat (400) @(posedge hclk);
    rd(ADDR_STATUS, s);
    check("status after cancel", s, 32'h0);
    send(CMD_DUMP);
    pull(b);
    check("pixel before reset", {24'h0, b}, {24'h0, expect_px(int'(CODE_MAX), ofs[0], gn[0])});
    send(CMD_RESET);
    repeat (200) @(posedge hclk);
    rd(ADDR_RX, s);
    repeat (400) @(posedge hclk);
    rd(ADDR_STATUS, s);
    check("status after reset command", s, 32'h0);
    send(CMD_DUMP);
    pull(b);
    check("pixel after reset", {24'h0, b}, {24'h0, expect_px(0, ofs[0], gn[0])});
    send(CMD_CANCEL);
    repeat (200) @(posedge hclk);
    rd(ADDR_RX, s);
    repeat (400) @(posedge hclk);
    rd(ADDR_STATUS, s);
    check("status after second cancel", s, 32'h0);
    close_out();
  end
endmodule
